// *** iors_pkg.sv ***
// Shared constants and mode types for the I/O register and serializer cell.
// Assumes one 50 MHz clock; the slow system clock is an enable derived from it.
package iors_pkg;

    // Clock figures
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 20;

    // Gearbox word and lane layout
    localparam int GEAR_W = 8;
    localparam int LANE_W = 4;
    localparam int LANE_A_LSB = 0;
    localparam int LANE_C_LSB = 4;
    localparam int WORD7_W = 7;

    // Edge-clock cycles per system clock period, by mode
    localparam logic [3:0] DIV_REG = 4'h8;
    localparam logic [3:0] DIV_GEAR7 = 4'h7;
    localparam logic [3:0] DIV_GEAR8 = 4'h8;
    localparam logic [3:0] DIV_GEAR4 = 4'h4;

    // Input delay line
    localparam int DLY_W = 5;
    localparam int DLY_TAPS = 32;
    localparam logic [4:0] FIXED_TAP_DEF = 5'h04;

    // FIFO in front of the gearbox
    localparam int FIFO_DEPTH_DEF = 16;

    // Output path modes
    typedef enum logic [2:0] {
        IORS_OUT_SDR = 3'h0,
        IORS_OUT_DDR = 3'h1,
        IORS_OUT_GEAR8 = 3'h3,
        IORS_OUT_GEAR7 = 3'h2,
        IORS_OUT_GEAR4X2 = 3'h6
    } iors_out_mode_t;

    // Input delay selection
    typedef enum logic [1:0] {
        IORS_DLY_NONE = 2'h0,
        IORS_DLY_FIXED = 2'h1,
        IORS_DLY_DYNAMIC = 2'h3
    } iors_dly_mode_t;

endpackage

// *** iors_fifo.sv ***
// Synchronous FIFO in front of the gearbox, flip-flop storage.
// Assumes both sides on mclk_i; ready is registered and exact.
`timescale 1ns/1ps
`default_nettype none
module iors_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("iors_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic ready_ff;
    logic push;
    logic pop;
    logic [CW-1:0] nxt_count;

    assign push = in_valid_i && ready_ff;
    assign pop = out_ready_i && (count_ff != '0);
    assign in_ready_o = ready_ff;
    assign out_valid_o = (count_ff != '0);
    assign out_data_o = mem_ff[rd_ptr_ff];

    always_comb
    begin
        nxt_count = count_ff;
        if (push && !pop)
        begin
            nxt_count = count_ff + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_count = count_ff - 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            ready_ff <= 1'b0;
        end
        else
        begin
            // Registered ready still exact: derived from next fill level
            ready_ff <= (nxt_count != DEPTH_C);
            count_ff <= nxt_count;
            if (push)
            begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// *** iors_cell.sv ***
// I/O cell logic: input capture, output and enable registers, output gearbox.
// Assumes mclk_i is the fast edge clock; pad inputs are asynchronous.
//
// How it works
// - Pad input can bypass delay and capture, giving data and clock outputs.
// - Single-rate input mode captures the pad in one system-clock register.
// - Double-rate input samples on rising and falling system edges, two streams.
// - Second output: single-rate data or falling sample; first: rising sample.
// - Selectable fixed input delay; bottom-edge cells add a 5-bit dynamic delay.
// - Output block takes first core bit outside gearbox modes, second only in double-rate.
// - Core output enable is registered to drive the pad enable output.
// - One system clock, qualified by clock enable, serves all three blocks, the output block only outside gearbox modes.
// - Local set/reset drives the capture, output, enable and gearbox stage registers to their configured value.
// - Gearbox runs as 7-to-1, 8-to-1, or two independent 4-to-1 lanes.
// - Gearbox first stage samples the parallel word on the system clock.
// - Second stage moves the word into the edge-clock registers.
// - Third stage shifts the word out serially to the pad on the edge clock.
`timescale 1ns/1ps
`default_nettype none
module iors_cell #(
    parameter int FIFO_DEPTH = iors_pkg::FIFO_DEPTH_DEF,
    parameter bit BOTTOM_EDGE = 1'b1,
    parameter logic [4:0] FIXED_TAP = iors_pkg::FIXED_TAP_DEF,
    parameter bit LSR_VAL = 1'b0
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic lsr_i,
    input wire iors_pkg::iors_out_mode_t out_mode_i,
    input wire iors_pkg::iors_dly_mode_t dly_mode_i,
    input wire logic ddr_in_mode_i,
    input wire logic [iors_pkg::DLY_W-1:0] dynamic_delay_setting_i,
    input wire logic pad_d_i,
    output logic bypass_input_o,
    output logic bypass_clock_out_o,
    output logic rise_capture_out_o,
    output logic fall_or_single_capture_out_o,
    input wire logic core_out_first_i,
    input wire logic core_out_second_i,
    input wire logic core_output_enable_i,
    output logic pad_q_o,
    output logic pad_enable_out_o,
    input wire logic [iors_pkg::GEAR_W-1:0] gear_data_i,
    input wire logic gear_valid_i,
    output logic gear_ready_o,
    output logic lane_a_serial_o,
    output logic lane_c_serial_o,
    output logic gear_underrun_o
);
    import iors_pkg::*;

    generate
        if (FIFO_DEPTH < 2)
        begin : g_bad_fifo
            $error("iors_cell: FIFO_DEPTH must be at least 2");
        end
    endgenerate

    // Edge-clock to system-clock divider
    logic [3:0] div_ff;
    logic [3:0] period;
    logic [3:0] half;
    logic rise_en;
    logic fall_en;
    logic sclk_ff;
    iors_out_mode_t mode_ff;
    logic gear_mode;

    // Input path
    logic pad_meta_ff;
    logic pad_sync_ff;
    logic [DLY_TAPS-1:0] dly_line_ff;
    logic [DLY_W-1:0] tap_sel;
    logic delayed_in;
    logic rise_cap_ff;
    logic fall_cap_ff;
    logic bypass_ff;

    // Output and enable registers
    logic first_hold_ff;
    logic second_hold_ff;
    logic pad_q_ff;
    logic pad_en_ff;

    // Gearbox
    logic fifo_valid;
    logic fifo_pop;
    logic [GEAR_W-1:0] fifo_data;
    logic [GEAR_W-1:0] stage1_ff;
    logic [GEAR_W-1:0] stage2_ff;
    logic [GEAR_W-1:0] shift_ff;
    logic [GEAR_W-1:0] word_in;
    logic lane_a_ff;
    logic lane_c_ff;
    logic underrun_ff;

    assign gear_mode = (mode_ff == IORS_OUT_GEAR8) || (mode_ff == IORS_OUT_GEAR7)
        || (mode_ff == IORS_OUT_GEAR4X2);

    // Ratio fixed per mode so a word always fills one system period
    always_comb
    begin
        case (mode_ff)
            IORS_OUT_GEAR7: period = DIV_GEAR7;
            IORS_OUT_GEAR8: period = DIV_GEAR8;
            IORS_OUT_GEAR4X2: period = DIV_GEAR4;
            default: period = DIV_REG;
        endcase
        half = period >> 1;
    end

    assign rise_en = (div_ff == 4'h0) && ce_i;
    assign fall_en = (div_ff == half) && ce_i;

    // Mode latched only at a period start so the divider never glitches
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            div_ff <= 4'h0;
            mode_ff <= IORS_OUT_SDR;
            sclk_ff <= 1'b0;
        end
        else
        begin
            if (div_ff == 4'h0 && out_mode_i != mode_ff)
            begin
                mode_ff <= out_mode_i;
                div_ff <= 4'h0;
            end
            else if (div_ff == period - 4'h1)
            begin
                div_ff <= 4'h0;
            end
            else
            begin
                div_ff <= div_ff + 4'h1;
            end
            sclk_ff <= (div_ff == period - 4'h1) || (div_ff < half - 4'h1);
        end
    end

    // Pad input crosses into mclk_i through two flops
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            pad_meta_ff <= 1'b0;
            pad_sync_ff <= 1'b0;
        end
        else
        begin
            pad_meta_ff <= pad_d_i;
            pad_sync_ff <= pad_meta_ff;
        end
    end

    // Bypass: no delay, no capture
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            bypass_ff <= 1'b0;
        end
        else
        begin
            bypass_ff <= pad_sync_ff;
        end
    end

    // Delay line, one edge-clock cycle per tap
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            dly_line_ff <= '0;
        end
        else
        begin
            dly_line_ff <= {dly_line_ff[DLY_TAPS-2:0], pad_sync_ff};
        end
    end

    // Dynamic setting only exists on bottom-edge cells; elsewhere it falls back to fixed
    always_comb
    begin
        if (dly_mode_i == IORS_DLY_DYNAMIC && BOTTOM_EDGE)
        begin
            tap_sel = dynamic_delay_setting_i;
        end
        else
        begin
            tap_sel = FIXED_TAP;
        end
        if (dly_mode_i == IORS_DLY_NONE)
        begin
            delayed_in = pad_sync_ff;
        end
        else
        begin
            delayed_in = dly_line_ff[tap_sel];
        end
    end

    // Input capture
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            rise_cap_ff <= 1'b0;
            fall_cap_ff <= 1'b0;
        end
        else if (lsr_i)
        begin
            rise_cap_ff <= LSR_VAL;
            fall_cap_ff <= LSR_VAL;
        end
        else
        begin
            if (rise_en && ddr_in_mode_i)
            begin
                rise_cap_ff <= delayed_in;
            end
            if (rise_en && !ddr_in_mode_i)
            begin
                fall_cap_ff <= delayed_in;
            end
            else if (fall_en && ddr_in_mode_i)
            begin
                fall_cap_ff <= delayed_in;
            end
        end
    end

    // Output data register; second bit held for the falling half
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            first_hold_ff <= 1'b0;
            second_hold_ff <= 1'b0;
            pad_q_ff <= 1'b0;
        end
        else if (lsr_i)
        begin
            first_hold_ff <= LSR_VAL;
            second_hold_ff <= LSR_VAL;
            pad_q_ff <= LSR_VAL;
        end
        else if (gear_mode)
        begin
            pad_q_ff <= shift_ff[LANE_A_LSB];
        end
        else
        begin
            if (rise_en)
            begin
                first_hold_ff <= core_out_first_i;
                second_hold_ff <= core_out_second_i;
                pad_q_ff <= core_out_first_i;
            end
            else if (fall_en && mode_ff == IORS_OUT_DDR)
            begin
                pad_q_ff <= second_hold_ff;
            end
        end
    end

    // Tri-state register
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            pad_en_ff <= 1'b0;
        end
        else if (lsr_i)
        begin
            pad_en_ff <= LSR_VAL;
        end
        else if (rise_en)
        begin
            pad_en_ff <= core_output_enable_i;
        end
    end

    // Gearbox input buffer; a stalled gearbox backs up to gear_ready_o
    iors_fifo #(
        .W(GEAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .in_valid_i(gear_valid_i),
        .in_ready_o(gear_ready_o),
        .in_data_i(gear_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    assign fifo_pop = rise_en && gear_mode && !lsr_i;

    // Unused upper bit in 7:1 forced low
    always_comb
    begin
        word_in = fifo_data;
        if (mode_ff == IORS_OUT_GEAR7)
        begin
            word_in[GEAR_W-1:WORD7_W] = '0;
        end
    end

    // Three pipeline stages, all advancing at the system rising edge
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            shift_ff <= '0;
            underrun_ff <= 1'b0;
        end
        else if (lsr_i)
        begin
            stage1_ff <= {GEAR_W{LSR_VAL}};
            stage2_ff <= {GEAR_W{LSR_VAL}};
            shift_ff <= {GEAR_W{LSR_VAL}};
        end
        else if (fifo_pop)
        begin
            // Empty FIFO repeats no stale word: zeros go out instead
            stage1_ff <= fifo_valid ? word_in : '0;
            underrun_ff <= !fifo_valid;
            stage2_ff <= stage1_ff;
            shift_ff <= stage2_ff;
        end
        else if (mode_ff == IORS_OUT_GEAR4X2)
        begin
            // Lanes shift apart so bit 4 never leaks into lane A
            shift_ff[LANE_A_LSB +: LANE_W] <= {1'b0, shift_ff[LANE_A_LSB+1 +: LANE_W-1]};
            shift_ff[LANE_C_LSB +: LANE_W] <= {1'b0, shift_ff[LANE_C_LSB+1 +: LANE_W-1]};
        end
        else
        begin
            shift_ff <= {1'b0, shift_ff[GEAR_W-1:1]};
        end
    end

    // Serial lane outputs
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            lane_a_ff <= 1'b0;
            lane_c_ff <= 1'b0;
        end
        else
        begin
            lane_a_ff <= gear_mode ? shift_ff[LANE_A_LSB] : 1'b0;
            lane_c_ff <= (mode_ff == IORS_OUT_GEAR4X2) ? shift_ff[LANE_C_LSB] : 1'b0;
        end
    end

    assign bypass_input_o = bypass_ff;
    assign bypass_clock_out_o = sclk_ff;
    assign rise_capture_out_o = rise_cap_ff;
    assign fall_or_single_capture_out_o = fall_cap_ff;
    assign pad_q_o = pad_q_ff;
    assign pad_enable_out_o = pad_en_ff;
    assign lane_a_serial_o = lane_a_ff;
    assign lane_c_serial_o = lane_c_ff;
    assign gear_underrun_o = underrun_ff;
endmodule
`default_nettype wire

// *** iors_checker.sv ***
// Port-level checker for the I/O cell.
// Assumes one clock, sync active-low reset, LSR_VAL of 0.
`timescale 1ns/1ps
`default_nettype none
module iors_checker (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic lsr_i,
    input wire iors_pkg::iors_out_mode_t out_mode_i,
    input wire logic pad_d_i,
    input wire logic bypass_input_o,
    input wire logic rise_capture_out_o,
    input wire logic fall_or_single_capture_out_o,
    input wire logic core_output_enable_i,
    input wire logic pad_q_o,
    input wire logic pad_enable_out_o,
    input wire logic gear_ready_o,
    input wire logic lane_a_serial_o,
    input wire logic lane_c_serial_o
);
    import iors_pkg::*;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    logic [3:0] age_ff;
    iors_out_mode_t last_ff;
    logic gear;
    // Mode is adopted only at divider count 0, so wait a few periods
    assign gear = (out_mode_i == IORS_OUT_GEAR8) || (out_mode_i == IORS_OUT_GEAR7) || (out_mode_i == IORS_OUT_GEAR4X2);
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            age_ff <= 4'h0;
            last_ff <= IORS_OUT_SDR;
        end
        else
        begin
            last_ff <= out_mode_i;
            if (out_mode_i != last_ff)
                age_ff <= 4'h0;
            else if (age_ff != 4'hf)
                age_ff <= age_ff + 4'h1;
        end
    end
    sequence s_lsr_held;
        lsr_i [*2];
    endsequence
    sequence s_pad_quiet;
        (!lsr_i && $stable(pad_d_i)) [*4];
    endsequence
    sequence s_oe_steady;
        (ce_i && !lsr_i && $stable(core_output_enable_i)) [*8];
    endsequence
    a_reset_zero: assert property (disable iff (1'b0) !rstn_i |=> !pad_q_o && !pad_enable_out_o
        && !gear_ready_o && !lane_a_serial_o && !lane_c_serial_o) else $error("outputs not cleared");
    a_ready_release: assert property (rstn_i && !$past(rstn_i) |=> gear_ready_o)
        else $error("fifo not ready after reset");
    a_lsr_clear: assert property (s_lsr_held |-> !pad_q_o && !pad_enable_out_o && !rise_capture_out_o
        && !fall_or_single_capture_out_o) else $error("local reset ignored");
    a_bypass_follow: assert property (s_pad_quiet |=> bypass_input_o == $past(pad_d_i))
        else $error("bypass data wrong");
    a_ce_freeze: assert property ((!ce_i && !lsr_i) [*2] |-> $stable(pad_enable_out_o)
        && $stable(rise_capture_out_o) && $stable(fall_or_single_capture_out_o)) else $error("moved without ce");
    a_oe_track: assert property (s_oe_steady |=> pad_enable_out_o == $past(core_output_enable_i))
        else $error("pad enable not registered");
    // Age is stale on the first edge of a new mode, so that edge is excluded
    a_lane_c_idle: assert property (out_mode_i != IORS_OUT_GEAR4X2 && out_mode_i == last_ff
        && age_ff >= 4'hc |-> !lane_c_serial_o) else $error("second lane active");
    a_gear_pad_lane: assert property (gear && out_mode_i == last_ff && age_ff >= 4'hc
        |-> pad_q_o == lane_a_serial_o) else $error("pad differs from lane");
endmodule
`default_nettype wire

// *** iors_pad_model.sv ***
// Pad buffer and far-side pin model for the I/O cell.
// Assumes a pull-up on the pin; drives at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module iors_pad_model (
    input wire logic mclk_i,
    input wire logic [1:0] mode_i,
    input wire logic val_i,
    input wire logic bclk_i,
    input wire logic pad_q_i,
    input wire logic pad_en_i,
    output logic pad_d_o
);
    logic [3:0] dly;
    logic [1:0] mode_q;
    logic val_q;
    logic line;
    // Released pin floats to the pull-up level
    assign line = pad_en_i ? pad_q_i : 1'b1;
    initial pad_d_o = 1'b0;
    initial dly = 4'h0;
    initial mode_q = 2'h0;
    initial val_q = 1'b0;
    // Bench controls taken at the rising edge so they never race the falling-edge drive
    always @(posedge mclk_i)
    begin
        mode_q <= mode_i;
        val_q <= val_i;
    end
    // Extra lag keeps samples off the half-period boundary
    always @(negedge mclk_i)
    begin
        dly <= {dly[2:0], bclk_i};
        case (mode_q)
            2'h0: pad_d_o <= val_q;
            2'h1: pad_d_o <= dly[3];
            2'h2: pad_d_o <= ~dly[3];
            default: pad_d_o <= line;
        endcase
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Testbench for the I/O cell: capture, output, gearbox and FIFO.
// Assumes default cell parameters; inputs move at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import iors_pkg::*;
    logic mclk_i, rstn_i, ce_i, lsr_i, ddr, pad_d, byp_d, byp_clk, rise_q, fall_q;
    logic first, second, oe, pad_q, pad_en, gvalid, gready, lane_a, lane_c, underrun, pm_val;
    logic [1:0] pm_mode;
    logic [4:0] dyn;
    logic [7:0] gdata;
    iors_out_mode_t out_mode;
    iors_dly_mode_t dly_mode;
    int miscompares, total_checks, n, n0, k;
    logic [159:0] sa, sc;
    logic [31:0] pa, pc;
    iors_out_mode_t gm[3] = '{IORS_OUT_GEAR8, IORS_OUT_GEAR7, IORS_OUT_GEAR4X2};
    int gk[3] = '{8, 7, 4};
    logic [7:0] ws[4] = '{8'hd2, 8'h5b, 8'he7, 8'h39};
    iors_cell dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .lsr_i(lsr_i), .out_mode_i(out_mode),
        .dly_mode_i(dly_mode), .ddr_in_mode_i(ddr), .dynamic_delay_setting_i(dyn), .pad_d_i(pad_d),
        .bypass_input_o(byp_d), .bypass_clock_out_o(byp_clk), .rise_capture_out_o(rise_q),
        .fall_or_single_capture_out_o(fall_q), .core_out_first_i(first), .core_out_second_i(second),
        .core_output_enable_i(oe), .pad_q_o(pad_q), .pad_enable_out_o(pad_en), .gear_data_i(gdata),
        .gear_valid_i(gvalid), .gear_ready_o(gready), .lane_a_serial_o(lane_a), .lane_c_serial_o(lane_c),
        .gear_underrun_o(underrun));
    iors_pad_model pm (.mclk_i(mclk_i), .mode_i(pm_mode), .val_i(pm_val), .bclk_i(byp_clk),
        .pad_q_i(pad_q), .pad_en_i(pad_en), .pad_d_o(pad_d));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(negedge mclk_i);
    endtask
    task automatic end_sim();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Cycles until the single-rate capture shows v
    task automatic lat(input logic v, output int c);
        c = 0;
        pm_val = v;
        while (fall_q !== v && c < 100)
        begin
            cyc(1);
            c++;
        end
        chk(fall_q, v);
    endtask
    // Holds valid up; ready is registered so sampling it here is safe
    task automatic wr(input logic [7:0] w);
        int c;
        c = 0;
        gdata = w;
        gvalid = 1'b1;
        while (gready !== 1'b1 && c < 50)
        begin
            cyc(1);
            c++;
        end
        chk(gready, 1);
        cyc(1);
    endtask
    function automatic bit hit(input logic [159:0] s, input logic [31:0] p, input int len);
        bit ok;
        for (int o = 0; o + len <= 160; o++)
        begin
            ok = 1'b1;
            for (int b = 0; b < len; b++)
                if (s[o+b] !== p[b])
                    ok = 1'b0;
            if (ok)
                return 1'b1;
        end
        return 1'b0;
    endfunction
    initial
    begin
        mclk_i = 1'b0;
        forever #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
    end
    initial
    begin
        #(CLK_PERIOD_NS * 20000);
        miscompares++;
        end_sim();
    end
    initial
    begin
        {rstn_i, lsr_i, ddr, first, second, oe, gvalid, pm_val, pm_mode} = '0;
        ce_i = 1'b1;
        dyn = 5'h00;
        gdata = 8'h00;
        out_mode = IORS_OUT_SDR;
        dly_mode = IORS_DLY_NONE;
        cyc(4);
        rstn_i = 1'b1;
        cyc(1);
        chk(gready, 1);
        pm_val = 1'b1;
        cyc(6);
        chk(byp_d, 1);
        n = 0;
        for (int i = 0; i < 8; i++)
        begin
            cyc(1);
            n += int'(byp_clk);
        end
        chk(n, 4);
        lat(1'b0, n);
        lat(1'b1, n0);
        chk(fall_q, 1);
        dly_mode = IORS_DLY_FIXED;
        lat(1'b0, n);
        cyc(40);
        lat(1'b1, n);
        chk(n >= 7 && n <= 17, 1);
        dly_mode = IORS_DLY_DYNAMIC;
        dyn = 5'h1f;
        lat(1'b0, n);
        cyc(40);
        lat(1'b1, n);
        chk(n - n0 >= 24 && n - n0 <= 40, 1);
        dly_mode = IORS_DLY_NONE;
        ddr = 1'b1;
        pm_mode = 2'h1;
        cyc(24);
        chk({rise_q, fall_q}, 2'b10);
        pm_mode = 2'h2;
        cyc(24);
        chk({rise_q, fall_q}, 2'b01);
        $display("input tests done");
        pm_mode = 2'h3;
        first = 1'b1;
        oe = 1'b1;
        cyc(12);
        chk({pad_q, pad_en}, 2'b11);
        out_mode = IORS_OUT_DDR;
        cyc(12);
        n = 0;
        k = 0;
        for (int i = 0; i < 8; i++)
        begin
            cyc(1);
            n += int'(pad_q);
            k += int'(pad_q === byp_clk);
        end
        chk(n, 4);
        chk(k >= 6, 1);
        out_mode = IORS_OUT_SDR;
        first = 1'b0;
        cyc(20);
        chk(byp_d, 0);
        ce_i = 1'b0;
        oe = 1'b0;
        cyc(16);
        chk({pad_en, byp_d}, 2'b10);
        ce_i = 1'b1;
        cyc(16);
        chk({pad_en, byp_d}, 2'b01);
        first = 1'b1;
        oe = 1'b1;
        cyc(12);
        lsr_i = 1'b1;
        cyc(2);
        chk({pad_q, pad_en}, 2'b00);
        lsr_i = 1'b0;
        cyc(12);
        chk({pad_q, pad_en}, 2'b11);
        $display("output tests done");
        out_mode = IORS_OUT_GEAR8;
        cyc(40);
        n = 0;
        gvalid = 1'b1;
        while (gready === 1'b1 && n < 40)
        begin
            gdata = n[7:0];
            cyc(1);
            n++;
        end
        gvalid = 1'b0;
        chk(n >= 16 && n <= 21, 1);
        cyc(200);
        chk(underrun, 1);
        for (int m = 0; m < 3; m++)
        begin
            out_mode = gm[m];
            k = gk[m];
            cyc(40);
            foreach (ws[i]) wr(ws[i]);
            gvalid = 1'b0;
            for (int t = 0; t < 160; t++)
            begin
                cyc(1);
                sa[t] = lane_a;
                sc[t] = lane_c;
            end
            pa = '0;
            pc = '0;
            for (int i = 0; i < 4; i++)
                for (int j = 0; j < k; j++)
                begin
                    pa[i*k+j] = ws[i][j];
                    pc[i*k+j] = ws[i][4+j];
                end
            chk(hit(sa, pa, 4 * k), 1);
            if (k == 4)
                chk(hit(sc, pc, 16), 1);
        end
        $display("gearbox tests done");
        end_sim();
    end
endmodule
bind iors_cell iors_checker u_chk (.mclk_i, .rstn_i, .ce_i, .lsr_i, .out_mode_i, .pad_d_i, .bypass_input_o,
    .rise_capture_out_o, .fall_or_single_capture_out_o, .core_output_enable_i, .pad_q_o, .pad_enable_out_o,
    .gear_ready_o, .lane_a_serial_o, .lane_c_serial_o);
`default_nettype wire
